// file: logic/unvm_pkg.sv
// Notes on behaviour
// - Holds 1 kbit of user storage that survives power removal.
// - Storage is organised as eight banks of 128 bits each.
// - Fabric reads return one byte per access through a clocked interface.
// - Upper three address bits select one of eight banks.
// - Lower four address bits select one of sixteen bytes in the bank.
// - Fabric can never write or erase the storage; only JTAG can.
// - Writes arrive through the JTAG programming path.
// - Contents can be read back over JTAG as well as by the fabric.
// - Storage can be erased and written alone, without other reprogramming.
// - Optionally decrypt JTAG data per operation before storing, on larger parts.
package unvm_pkg;
    localparam int         BANKS      = 8;
    localparam int         BANK_BITS  = 128;
    localparam int         BYTES_PB   = 16;
    localparam int         ADDR_W     = 7;
    localparam int         BANK_W     = 3;
    localparam int         BYTE_W     = 4;
    localparam int         DATA_W     = 8;
    localparam int         WORDS      = BANKS * BYTES_PB;
    localparam int         BANK_LSB   = 4;
    localparam logic [7:0] ERASED_VAL = 8'hff;
    localparam logic [3:0] LAST_BYTE  = 4'hf;

    // Programming port commands
    typedef enum logic [1:0] {
        UNVM_CMD_NONE  = 2'b00,
        UNVM_CMD_ERASE = 2'b01,
        UNVM_CMD_WRITE = 2'b10,
        UNVM_CMD_READ  = 2'b11
    } unvm_cmd_t;

    typedef enum logic [1:0] {
        UNVM_ST_IDLE  = 2'b00,
        UNVM_ST_ERASE = 2'b01,
        UNVM_ST_WRITE = 2'b10,
        UNVM_ST_READ  = 2'b11
    } unvm_state_t;
endpackage

// file: logic/unvm_mem.sv
// Byte array with one write port and two registered read ports
module unvm_mem (
    // Clock
    input  wire logic                         mclk,
    // Write port
    input  wire logic                         we,
    input  wire logic [unvm_pkg::ADDR_W-1:0]  waddr,
    input  wire logic [unvm_pkg::DATA_W-1:0]  wdata,
    // Read ports
    input  wire logic [unvm_pkg::ADDR_W-1:0]  raddr_a,
    output logic      [unvm_pkg::DATA_W-1:0]  rdata_a,
    input  wire logic [unvm_pkg::ADDR_W-1:0]  raddr_b,
    output logic      [unvm_pkg::DATA_W-1:0]  rdata_b
);
    // No reset: stands in for cells that keep data through power loss
    logic [unvm_pkg::DATA_W-1:0] cells [unvm_pkg::WORDS];

    always_ff @(posedge mclk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata_a <= cells[raddr_a];
        rdata_b <= cells[raddr_b];
    end
endmodule // unvm_mem

// file: logic/unvm_aes_stage.sv
// Per-byte decryption stage; keystream XOR stands in for the cipher core
module unvm_aes_stage (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Control
    input  wire logic                        enable,
    input  wire logic                        restart,
    input  wire logic                        step,
    // Data
    input  wire logic [unvm_pkg::DATA_W-1:0] din,
    output logic      [unvm_pkg::DATA_W-1:0] dout
);
    logic [unvm_pkg::DATA_W-1:0] lfsr_r;
    logic [unvm_pkg::DATA_W-1:0] lfsr_nxt;
    localparam logic [7:0] SEED = 8'ha5;

    // Keystream advances once per byte consumed
    assign lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    assign dout     = enable ? (din ^ lfsr_r) : din;

    always_ff @(posedge mclk) begin
        if (rst || restart) begin
            lfsr_r <= SEED;
        end else if (step) begin
            lfsr_r <= lfsr_nxt;
        end
    end
endmodule // unvm_aes_stage

// file: logic/unvm_read_port.sv
// User nonvolatile memory: fabric byte read port plus programming port
module unvm_read_port #(
    parameter bit AES_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // Fabric read port (no write path exists here)
    input  wire logic [unvm_pkg::ADDR_W-1:0]  user_nvm_addr,
    output logic      [unvm_pkg::DATA_W-1:0]  user_nvm_data,
    // Programming port from the JTAG controller
    input  wire logic                         prog_valid,
    input  wire unvm_pkg::unvm_cmd_t          prog_cmd,
    input  wire logic [unvm_pkg::BANK_W-1:0]  prog_bank,
    input  wire logic                         prog_decrypt,
    input  wire logic [unvm_pkg::DATA_W-1:0]  prog_wdata,
    output logic                              prog_busy,
    output logic                              prog_rvalid,
    output logic      [unvm_pkg::DATA_W-1:0]  prog_rdata
);
    unvm_pkg::unvm_state_t       state_r;
    unvm_pkg::unvm_state_t       state_nxt;
    logic [unvm_pkg::BANK_W-1:0] bank_r;
    logic [unvm_pkg::BYTE_W-1:0] idx_r;
    logic                        dec_r;
    logic                        rd_pend_r;
    logic [unvm_pkg::DATA_W-1:0] user_q;
    logic [unvm_pkg::DATA_W-1:0] prog_q;
    logic [unvm_pkg::DATA_W-1:0] plain;

    // Address split: bank from the top three bits, byte from the bottom four
    wire [unvm_pkg::BANK_W-1:0] user_bank = user_nvm_addr[unvm_pkg::ADDR_W-1:unvm_pkg::BANK_LSB];
    wire [unvm_pkg::BYTE_W-1:0] user_byte = user_nvm_addr[unvm_pkg::BYTE_W-1:0];
    wire [unvm_pkg::ADDR_W-1:0] user_ra   = {user_bank, user_byte};
    wire [unvm_pkg::ADDR_W-1:0] prog_a    = {bank_r, idx_r};

    // Only the programming sequencer drives the write port
    wire start     = prog_valid && (state_r == unvm_pkg::UNVM_ST_IDLE);
    wire last      = (idx_r == unvm_pkg::LAST_BYTE);
    wire do_erase  = (state_r == unvm_pkg::UNVM_ST_ERASE);
    wire do_write  = (state_r == unvm_pkg::UNVM_ST_WRITE) && prog_valid;
    wire mem_we    = do_erase || do_write;
    wire dec_on    = dec_r && AES_PRESENT;
    wire [unvm_pkg::DATA_W-1:0] mem_wd = do_erase ? unvm_pkg::ERASED_VAL : plain;
    wire do_read   = (state_r == unvm_pkg::UNVM_ST_READ);

    unvm_mem u_mem (
        .mclk    (mclk),
        .we      (mem_we),
        .waddr   (prog_a),
        .wdata   (mem_wd),
        .raddr_a (user_ra),
        .rdata_a (user_q),
        .raddr_b (prog_a),
        .rdata_b (prog_q)
    );

    unvm_aes_stage u_aes (
        .mclk    (mclk),
        .rst     (rst),
        .enable  (dec_on),
        .restart (start),
        .step    (do_write),
        .din     (prog_wdata),
        .dout    (plain)
    );

    // Sequencer: erase, write and readback each sweep one bank of 16 bytes
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            unvm_pkg::UNVM_ST_IDLE: begin
                if (prog_valid) begin
                    unique case (prog_cmd)
                        unvm_pkg::UNVM_CMD_ERASE: state_nxt = unvm_pkg::UNVM_ST_ERASE;
                        unvm_pkg::UNVM_CMD_WRITE: state_nxt = unvm_pkg::UNVM_ST_WRITE;
                        unvm_pkg::UNVM_CMD_READ:  state_nxt = unvm_pkg::UNVM_ST_READ;
                        unvm_pkg::UNVM_CMD_NONE:  state_nxt = unvm_pkg::UNVM_ST_IDLE;
                    endcase
                end
            end
            unvm_pkg::UNVM_ST_ERASE: if (last) state_nxt = unvm_pkg::UNVM_ST_IDLE;
            unvm_pkg::UNVM_ST_WRITE: if (do_write && last) state_nxt = unvm_pkg::UNVM_ST_IDLE;
            unvm_pkg::UNVM_ST_READ:  if (last) state_nxt = unvm_pkg::UNVM_ST_IDLE;
        endcase
    end

    // Control registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r   <= unvm_pkg::UNVM_ST_IDLE;
            bank_r    <= '0;
            idx_r     <= '0;
            dec_r     <= 1'b0;
            rd_pend_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            rd_pend_r <= do_read;
            if (start) begin
                bank_r <= prog_bank;
                idx_r  <= '0;
                dec_r  <= prog_decrypt;
            end else if (do_erase || do_write || do_read) begin
                idx_r  <= idx_r + 4'h1;
            end
        end
    end

    // Output registers; fabric byte follows the address two edges later
    always_ff @(posedge mclk) begin
        if (rst) begin
            user_nvm_data <= '0;
            prog_busy     <= 1'b0;
            prog_rvalid   <= 1'b0;
            prog_rdata    <= '0;
        end else begin
            user_nvm_data <= user_q;
            prog_busy     <= (state_nxt != unvm_pkg::UNVM_ST_IDLE);
            prog_rvalid   <= rd_pend_r;
            if (rd_pend_r) begin
                prog_rdata <= prog_q;
            end
        end
    end
endmodule // unvm_read_port

// file: testbench/unvm_read_port_chk.sv
// Port checker for the user memory read port
module unvm_read_port_chk (
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        rst,
    // Fabric and programming ports
    input wire logic [unvm_pkg::ADDR_W-1:0] user_nvm_addr,
    input wire logic [unvm_pkg::DATA_W-1:0] user_nvm_data,
    input wire logic                        prog_valid,
    input wire unvm_pkg::unvm_cmd_t         prog_cmd,
    input wire logic                        prog_busy,
    input wire logic                        prog_rvalid,
    input wire logic [unvm_pkg::DATA_W-1:0] prog_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Command takes, split by kind
    wire take = prog_valid && !prog_busy;
    wire tk_e = take && prog_cmd == unvm_pkg::UNVM_CMD_ERASE;
    wire tk_w = take && prog_cmd == unvm_pkg::UNVM_CMD_WRITE;
    wire tk_r = take && prog_cmd == unvm_pkg::UNVM_CMD_READ;
    AST_RST: assert property (disable iff (1'b0) rst |=> user_nvm_data == 8'h00
        && !prog_busy && !prog_rvalid) else $error("reset outputs wrong");
    AST_HOLD: assert property ((!prog_busy && $stable(user_nvm_addr))[*4]
        |=> $stable(user_nvm_data)) else $error("byte moved with address held");
    AST_IDLE: assert property (!prog_busy && !(take && prog_cmd != 2'b00)
        |=> !prog_busy) else $error("storage busy without a command");
    AST_TAKE: assert property (take && prog_cmd != 2'b00 |=> prog_busy)
        else $error("command not taken");
    AST_ERASE: assert property (tk_e |=> prog_busy[*8] ##1 prog_busy[*8] ##1 !prog_busy)
        else $error("erase length wrong");
    AST_WRITE: assert property (tk_w |=> prog_busy[*8] ##[8:20] !prog_busy)
        else $error("write length wrong");
    AST_READ: assert property (tk_r |-> ##3 prog_rvalid[*8] ##1 prog_rvalid[*8]
        ##1 !prog_rvalid) else $error("readback pulses wrong");
    // Reset may clear the byte, so the edge right after reset is left out
    AST_RDATA: assert property (!prog_rvalid && !$past(rst) |-> $stable(prog_rdata))
        else $error("readback byte moved between pulses");
endmodule // unvm_read_port_chk

bind unvm_read_port unvm_read_port_chk u_chk (.mclk(mclk), .rst(rst),
    .user_nvm_addr(user_nvm_addr), .user_nvm_data(user_nvm_data), .prog_valid(prog_valid),
    .prog_cmd(prog_cmd), .prog_busy(prog_busy), .prog_rvalid(prog_rvalid),
    .prog_rdata(prog_rdata));

// file: testbench/unvm_fabric_model.sv
// Fabric reader: launches each address half a cycle after capture
module unvm_fabric_model (
    // Clock
    input  wire logic                        mclk,
    // Wanted address and the pins
    input  wire logic [unvm_pkg::ADDR_W-1:0] want_addr,
    output logic      [unvm_pkg::ADDR_W-1:0] user_nvm_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [unvm_pkg::ADDR_W-1:0] want_r;
    initial user_nvm_addr = 7'h00;
    // Launching on the falling edge keeps the pins steady across each rising edge
    always @(posedge mclk) want_r <= want_addr;
    always @(negedge mclk) user_nvm_addr <= want_r;
endmodule // unvm_fabric_model

// file: testbench/tb_user_nvm_byte_read_port.sv
// Bench: programs all banks, then streams fabric reads back to back
module tb_user_nvm_byte_read_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, valid = 1'b0, busy, rv;
    logic dec = 1'b0;
    unvm_pkg::unvm_cmd_t cmd = unvm_pkg::UNVM_CMD_NONE;
    logic [2:0] bank = 3'h0;
    logic [6:0] want = 7'h00, addr;
    logic [6:0] h [300];
    logic [7:0] wdata = 8'h00, data, rdata;
    logic [7:0] exp_mem [128];
    logic [31:0] rs = 32'h00013504;
    int failures = 0, checks = 0;
    unvm_fabric_model u_fab (.mclk(mclk), .want_addr(want), .user_nvm_addr(addr));
    unvm_read_port #(.AES_PRESENT(1'b1)) DUT (.mclk(mclk), .rst(rst), .user_nvm_addr(addr),
        .user_nvm_data(data), .prog_valid(valid), .prog_cmd(cmd), .prog_bank(bank),
        .prog_decrypt(dec), .prog_wdata(wdata), .prog_busy(busy), .prog_rvalid(rv),
        .prog_rdata(rdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Decrypt keystream step; restarts from 8'ha5 with every command
    function automatic logic [7:0] ks_step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One command; bytes of a write follow the command cycle with no gap
    task automatic prog(input unvm_pkg::unvm_cmd_t c, input logic [2:0] b);
        int n;
        int k;
        logic [7:0] ks;
        k = 0;
        ks = 8'ha5;
        @(negedge mclk);
        valid = 1'b1;
        cmd = c;
        bank = b;
        for (n = 0; n < 16; n++) begin
            if (c == unvm_pkg::UNVM_CMD_ERASE) exp_mem[{b, n[3:0]}] = 8'hff;
            if (c == unvm_pkg::UNVM_CMD_WRITE) begin
                @(negedge mclk);
                rs = xs(rs);
                wdata = rs[7:0];
                exp_mem[{b, n[3:0]}] = dec ? (rs[7:0] ^ ks) : rs[7:0];
                ks = ks_step(ks);
            end
        end
        @(negedge mclk) valid = 1'b0;
        // Readback pulses trail busy by two cycles, so wait for both to drop
        for (n = 0; n < 40 && (busy !== 1'b0 || rv !== 1'b0 || n < 4); n++) begin
            @(negedge mclk);
            if (rv === 1'b1 && k < 16) chk(rdata, exp_mem[{b, k[3:0]}]);
            if (rv === 1'b1) k++;
        end
        chk({7'h00, busy}, 8'h00);
        if (c == unvm_pkg::UNVM_CMD_READ) chk(k[7:0], 8'h10);
    endtask
    // Free-running fabric clock
    initial forever #5 mclk = ~mclk;
    // Watchdog, well past the expected run
    initial begin
        #100us;
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        for (int b = 0; b < 8; b++) prog(unvm_pkg::UNVM_CMD_ERASE, b[2:0]);
        for (int b = 0; b < 8; b++) prog(unvm_pkg::UNVM_CMD_WRITE, b[2:0]);
        prog(unvm_pkg::UNVM_CMD_ERASE, 3'h3);
        prog(unvm_pkg::UNVM_CMD_NONE, 3'h0);
        prog(unvm_pkg::UNVM_CMD_READ, 3'h3);
        prog(unvm_pkg::UNVM_CMD_READ, 3'h5);
        // Decrypted write, then read back the plain bytes
        dec = 1'b1;
        prog(unvm_pkg::UNVM_CMD_WRITE, 3'h6);
        dec = 1'b0;
        prog(unvm_pkg::UNVM_CMD_READ, 3'h6);
        $display("test programming port done");
        // New address every cycle, with held stretches; end addresses first
        for (int i = 0; i < 300; i++) begin
            @(negedge mclk);
            rs = xs(rs);
            h[i] = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : rs[8] ? h[i-1] : rs[6:0];
            want = h[i];
            if (i >= 3) chk(data, exp_mem[h[i-3]]);
        end
        $display("test fabric reads done");
        // Mid-run reset: outputs clear, stored bytes survive it
        @(negedge mclk);
        rst = 1'b1;
        @(negedge mclk);
        chk(data, 8'h00);
        chk(rdata, 8'h00);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        chk(data, exp_mem[want]);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // tb_user_nvm_byte_read_port
